// ---- design/ias_accept_seq.sv ----
`timescale 1ns/1ps
module ias_accept_seq
    import ias_pkg::*;
#(
    parameter int EXT_LINES = EXT_N,
    parameter int PER_LINES = PER_N
) (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 nmi_pin,
    input  wire logic [EXT_LINES-1:0] ext_request_lines,
    input  wire logic [PER_LINES-1:0] periph_req,
    input  wire logic [3:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_we,
    input  wire logic                 reg_re,
    output logic      [31:0]          reg_rdata,
    input  wire logic                 instr_end,
    input  wire logic                 instr_ccr_op,
    input  wire logic                 rte_req,
    input  wire logic [15:0]          pc_in,
    input  wire logic [7:0]           ccr_in,
    input  wire logic [15:0]          sp_in,
    output logic                      cpu_hold,
    output logic      [15:0]          pc_out,
    output logic                      pc_load,
    output logic      [7:0]           condition_code_reg,
    output logic                      ccr_load,
    output logic      [15:0]          stack_pointer_reg,
    output logic                      sp_load,
    output logic      [15:0]          mem_addr,
    output logic      [15:0]          mem_wdata,
    output logic                      mem_we,
    output logic                      mem_re,
    input  wire logic [15:0]          mem_rdata
);
    ////////////////////////////////////////////////////////////////////////
    ias_state_t       state_ff;
    logic [31:0]      ctrl_ff;
    logic [31:0]      per_en_ff;
    logic [31:0]      rdata_ff;
    logic             arm_ff;
    logic             seq_done_ff;
    logic [4:0]       vec_ff;
    logic [15:0]      sp_ff;
    logic [7:0]       ccr_ff;
    logic [15:0]      addr_ff;
    logic [15:0]      wdata_ff;
    logic             we_ff;
    logic             re_ff;
    logic [15:0]      pc_out_ff;
    logic             pc_load_ff;
    logic [7:0]       ccr_out_ff;
    logic             ccr_load_ff;
    logic [15:0]      sp_out_ff;
    logic             sp_load_ff;
    logic [SRC_N-1:0] active;
    logic [4:0]       sel_idx;
    logic             any_req;
    logic             mask_eff;
    logic             boundary;
    logic             accept;
    logic [DET_N-1:0] clr_vec;

    ias_det_if #(.N(DET_N)) det_bus ();

    ////////////////////////////////////////////////////////////////////////
    // line 0 is the non-maskable pin, lines 1..8 the external lines
    assign det_bus.pin         = {ext_request_lines, nmi_pin};
    assign det_bus.edge_mode   = {ctrl_ff[CTRL_EDGE_LSB +: EXT_N], 1'b1};
    assign det_bus.active_high = {{EXT_N{1'b0}}, ctrl_ff[CTRL_NMI_RISE]};
    assign det_bus.enable      = {ctrl_ff[CTRL_EN_LSB +: EXT_N], 1'b1};
    assign det_bus.clear       = clr_vec;

    ias_req_detect #(.N(DET_N)) u_detect (
        .clock (clock),
        .rst   (rst),
        .d     (det_bus)
    );

    // index order is priority order: nmi, ext 0..7, then peripherals
    assign active = {periph_req & per_en_ff[PER_N-1:0], det_bus.req};

    function automatic logic [4:0] ias_pick(input logic [SRC_N-1:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int k = SRC_N - 1; k >= 0; k--) begin
            if (v[k]) begin
                idx = 5'(k);
            end
        end
        return idx;
    endfunction : ias_pick

    assign sel_idx = ias_pick(active);
    assign any_req = |active;

    // right after a sequence the core has not seen the new mask yet
    assign mask_eff = seq_done_ff | ccr_in[CCR_I_BIT];

    // ccr-changing instructions skip detection for one boundary
    assign boundary = (instr_end && !instr_ccr_op && arm_ff) || seq_done_ff;

    assign accept = (state_ff == ST_IDLE) && !rte_req && boundary && any_req &&
                    ((sel_idx == 5'h00) || !mask_eff);

    always_comb begin
        clr_vec = '0;
        if (accept && (sel_idx < 5'(DET_N))) begin
            clr_vec[sel_idx[3:0]] = 1'b1;
        end
    end

    assign cpu_hold = (state_ff != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // nmi included stays off until the first instruction has run
    always_ff @(posedge clock) begin
        if (rst) begin
            arm_ff <= 1'b0;
        end else if (instr_end && (state_ff == ST_IDLE)) begin
            arm_ff <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            seq_done_ff <= 1'b0;
        end else begin
            seq_done_ff <= (state_ff == ST_VEC_LD);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= ST_RST_RD;
            vec_ff   <= 5'h00;
            sp_ff    <= 16'h0000;
            ccr_ff   <= 8'h00;
            addr_ff  <= 16'h0000;
            wdata_ff <= 16'h0000;
            we_ff    <= 1'b0;
            re_ff    <= 1'b0;
        end else begin
            unique case (state_ff)
                ST_RST_RD: begin
                    re_ff    <= 1'b1;
                    addr_ff  <= VEC_RESET_ADDR;
                    state_ff <= ST_RST_WT;
                end
                ST_RST_WT: begin
                    re_ff    <= 1'b0;
                    state_ff <= ST_RST_LD;
                end
                ST_RST_LD: begin
                    state_ff <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (rte_req) begin
                        re_ff    <= 1'b1;
                        addr_ff  <= sp_in;
                        sp_ff    <= sp_in + WORD_BYTES + WORD_BYTES;
                        state_ff <= ST_POP_PC;
                    end else if (accept) begin
                        // even stack pointer is assumed, words are not split
                        we_ff    <= 1'b1;
                        addr_ff  <= sp_in - WORD_BYTES;
                        wdata_ff <= pc_in;
                        sp_ff    <= sp_in - WORD_BYTES - WORD_BYTES;
                        ccr_ff   <= ccr_in;
                        vec_ff   <= sel_idx + VEC_FIRST_NUM;
                        state_ff <= ST_PUSH_CC;
                    end
                end
                ST_PUSH_CC: begin
                    addr_ff  <= sp_ff;
                    wdata_ff <= {ccr_ff, 8'h00};
                    state_ff <= ST_VEC_RD;
                end
                ST_VEC_RD: begin
                    we_ff    <= 1'b0;
                    re_ff    <= 1'b1;
                    addr_ff  <= {10'h000, vec_ff, 1'b0};
                    state_ff <= ST_VEC_WT;
                end
                ST_VEC_WT: begin
                    re_ff    <= 1'b0;
                    state_ff <= ST_VEC_LD;
                end
                ST_VEC_LD: begin
                    state_ff <= ST_IDLE;
                end
                ST_POP_PC: begin
                    addr_ff  <= addr_ff + WORD_BYTES;
                    state_ff <= ST_POP_CAP;
                end
                ST_POP_CAP: begin
                    re_ff    <= 1'b0;
                    ccr_ff   <= mem_rdata[15:8];
                    state_ff <= ST_POP_FIN;
                end
                ST_POP_FIN: begin
                    state_ff <= ST_IDLE;
                end
                default: begin
                    we_ff    <= 1'b0;
                    re_ff    <= 1'b0;
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // loads toward the core, one-cycle pulses with registered data
    always_ff @(posedge clock) begin
        if (rst) begin
            pc_out_ff   <= 16'h0000;
            pc_load_ff  <= 1'b0;
            ccr_out_ff  <= CCR_I_MASK;
            ccr_load_ff <= 1'b0;
            sp_out_ff   <= 16'h0000;
            sp_load_ff  <= 1'b0;
        end else begin
            pc_load_ff  <= 1'b0;
            ccr_load_ff <= 1'b0;
            sp_load_ff  <= 1'b0;
            unique case (state_ff)
                ST_RST_LD: begin
                    pc_out_ff   <= mem_rdata;
                    pc_load_ff  <= 1'b1;
                    ccr_out_ff  <= ccr_in | CCR_I_MASK;
                    ccr_load_ff <= 1'b1;
                end
                ST_VEC_LD: begin
                    pc_out_ff   <= mem_rdata;
                    pc_load_ff  <= 1'b1;
                    ccr_out_ff  <= ccr_ff | CCR_I_MASK;
                    ccr_load_ff <= 1'b1;
                    sp_out_ff   <= sp_ff;
                    sp_load_ff  <= 1'b1;
                end
                ST_POP_FIN: begin
                    pc_out_ff   <= mem_rdata;
                    pc_load_ff  <= 1'b1;
                    ccr_out_ff  <= ccr_ff;
                    ccr_load_ff <= 1'b1;
                    sp_out_ff   <= sp_ff;
                    sp_load_ff  <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    assign pc_out             = pc_out_ff;
    assign pc_load            = pc_load_ff;
    assign condition_code_reg = ccr_out_ff;
    assign ccr_load           = ccr_load_ff;
    assign stack_pointer_reg  = sp_out_ff;
    assign sp_load            = sp_load_ff;
    assign mem_addr           = addr_ff;
    assign mem_wdata          = wdata_ff;
    assign mem_we             = we_ff;
    assign mem_re             = re_ff;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_ff   <= CTRL_RST;
            per_en_ff <= PER_EN_RST;
        end else if (reg_we) begin
            if (reg_addr == OFS_CTRL) begin
                ctrl_ff <= {15'h0000, reg_wdata[CTRL_NMI_RISE:0]};
            end
            if (reg_addr == OFS_PER_EN) begin
                per_en_ff <= {13'h0000, reg_wdata[PER_N-1:0]};
            end
        end
    end

    // unmapped offsets read zero
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (reg_re) begin
            unique case (reg_addr)
                OFS_CTRL:    rdata_ff <= ctrl_ff;
                OFS_PER_EN:  rdata_ff <= per_en_ff;
                OFS_PENDING: rdata_ff <= {4'h0, active};
                OFS_STATUS:  rdata_ff <= {18'h00000, arm_ff, cpu_hold, state_ff,
                                          3'h0, vec_ff};
                default:     rdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_ff;
endmodule : ias_accept_seq

// ---- include/ias_pkg.sv ----
package ias_pkg;
    localparam int          EXT_N          = 8;
    localparam int          PER_N          = 19;
    localparam int          DET_N          = 9;
    localparam int          SRC_N          = 28;
    // register offsets on the plain register port
    localparam logic [3:0]  OFS_CTRL       = 4'h0;
    localparam logic [3:0]  OFS_PER_EN     = 4'h4;
    localparam logic [3:0]  OFS_PENDING    = 4'h8;
    localparam logic [3:0]  OFS_STATUS     = 4'hC;
    localparam int          CTRL_EN_LSB    = 0;
    localparam int          CTRL_EDGE_LSB  = 8;
    localparam int          CTRL_NMI_RISE  = 16;
    localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
    localparam logic [31:0] PER_EN_RST     = 32'h0000_0000;
    // vector table layout
    localparam logic [15:0] VEC_RESET_ADDR = 16'h0000;
    localparam logic [4:0]  VEC_FIRST_NUM  = 5'h03;
    localparam logic [15:0] WORD_BYTES     = 16'h0002;
    localparam int          CCR_I_BIT      = 7;
    localparam logic [7:0]  CCR_I_MASK     = 8'h80;

    typedef enum logic [3:0] {
        ST_RST_RD  = 4'h0,
        ST_RST_WT  = 4'h1,
        ST_RST_LD  = 4'h3,
        ST_IDLE    = 4'h2,
        ST_PUSH_CC = 4'h6,
        ST_VEC_RD  = 4'h7,
        ST_VEC_WT  = 4'h5,
        ST_VEC_LD  = 4'h4,
        ST_POP_PC  = 4'hC,
        ST_POP_CAP = 4'hD,
        ST_POP_FIN = 4'hF
    } ias_state_t;
endpackage : ias_pkg

// ---- include/ias_det_if.sv ----
`timescale 1ns/1ps
interface ias_det_if #(parameter int N = 9);
    logic [N-1:0] pin;
    logic [N-1:0] edge_mode;
    logic [N-1:0] active_high;
    logic [N-1:0] enable;
    logic [N-1:0] clear;
    logic [N-1:0] req;
    modport ctl (output pin, edge_mode, active_high, enable, clear, input req);
    modport det (input pin, edge_mode, active_high, enable, clear, output req);
endinterface : ias_det_if

// ---- design/ias_req_detect.sv ----
`timescale 1ns/1ps
module ias_req_detect #(
    parameter int N = 9
) (
    input  wire logic clock,
    input  wire logic rst,
    ias_det_if.det    d
);
    ////////////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < N; i++) begin : g_line
        logic s1_ff;
        logic s2_ff;
        logic prev_ff;
        logic lat_ff;
        logic act;
        logic prev_act;
        logic hit;

        // s1_ff feeds s2_ff only; pins are asynchronous
        always_ff @(posedge clock) begin
            if (rst) begin
                s1_ff   <= 1'b1;
                s2_ff   <= 1'b1;
                prev_ff <= 1'b1;
            end else begin
                s1_ff   <= d.pin[i];
                s2_ff   <= s1_ff;
                prev_ff <= s2_ff;
            end
        end

        assign act      = d.active_high[i] ? s2_ff : ~s2_ff;
        assign prev_act = d.active_high[i] ? prev_ff : ~prev_ff;
        assign hit      = act & ~prev_act;

        // a new edge in the clear cycle is kept
        always_ff @(posedge clock) begin
            if (rst) begin
                lat_ff <= 1'b0;
            end else if (hit && d.enable[i]) begin
                lat_ff <= 1'b1;
            end else if (d.clear[i] || !d.edge_mode[i]) begin
                lat_ff <= 1'b0;
            end
        end

        assign d.req[i] = d.edge_mode[i] ? lat_ff : (act & d.enable[i]);
    end
endmodule : ias_req_detect

// ---- tb/ias_accept_checker.sv ----
`timescale 1ns/1ps
module ias_accept_checker
    import ias_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        instr_end,
    input wire logic        instr_ccr_op,
    input wire logic        rte_req,
    input wire logic [15:0] pc_in,
    input wire logic [7:0]  ccr_in,
    input wire logic [15:0] sp_in,
    input wire logic        cpu_hold,
    input wire logic [15:0] pc_out,
    input wire logic        pc_load,
    input wire logic [7:0]  condition_code_reg,
    input wire logic        ccr_load,
    input wire logic [15:0] stack_pointer_reg,
    input wire logic        sp_load,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic        mem_we,
    input wire logic        mem_re,
    input wire logic [15:0] mem_rdata
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    property p_reset_fetch;
        $fell(rst) |=> mem_re && mem_addr == VEC_RESET_ADDR;
    endproperty
    a_reset_fetch: assert property (p_reset_fetch) else $error("reset fetch missing");
    property p_push;
        mem_we && !$past(mem_we) |-> mem_addr == sp_in - 16'h0002 && mem_wdata == pc_in
            ##1 mem_we && mem_addr == sp_in - 16'h0004 && mem_wdata == {ccr_in, 8'h00};
    endproperty
    a_push: assert property (p_push) else $error("stacking order wrong");
    // the load pulses follow the vector read by two edges and last one cycle
    property p_mask;
        $fell(mem_we) |-> ##2 pc_load && ccr_load && sp_load
            && condition_code_reg[CCR_I_BIT] && stack_pointer_reg == sp_in - 16'h0004;
    endproperty
    a_mask: assert property (p_mask) else $error("mask bit not set after entry");
    property p_vec_range;
        mem_re && $past(mem_we) |-> mem_addr >= 16'h0006 && mem_addr <= 16'h003C && !mem_addr[0];
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("vector out of range");
    property p_vec_load;
        $fell(mem_we) |-> ##3 pc_out == $past(mem_rdata, 2);
    endproperty
    a_vec_load: assert property (p_vec_load) else $error("handler address wrong");
    property p_ret_pop;
        rte_req && !cpu_hold |=> mem_re && mem_addr == sp_in
            ##1 mem_re && mem_addr == sp_in + 16'h0002;
    endproperty
    a_ret_pop: assert property (p_ret_pop) else $error("return pop order wrong");
    // pc word arrives the edge before the load, ccr word one edge earlier
    property p_ret_load;
        rte_req && !cpu_hold |-> ##4 pc_load && ccr_load && pc_out == $past(mem_rdata)
            && condition_code_reg == 8'($past(mem_rdata, 2) >> 8);
    endproperty
    a_ret_load: assert property (p_ret_load) else $error("return restore wrong");
    // the boundary right after a sequence end is excluded: non-maskable may enter there
    property p_ccr_defer;
        instr_end && instr_ccr_op && !cpu_hold && !$past(cpu_hold) && !pc_load && !$past(pc_load)
            && !rte_req |=> !cpu_hold;
    endproperty
    a_ccr_defer: assert property (p_ccr_defer) else $error("entry at ccr boundary");
    c_entry: cover property ($fell(mem_we));
    c_rte: cover property (rte_req && !cpu_hold);
    c_defer: cover property (instr_end && instr_ccr_op && !cpu_hold);
endmodule : ias_accept_checker
////////////////////////////////////////////////////////////////////////////////
bind ias_accept_seq ias_accept_checker u_ias_accept_checker (
    .clock, .rst, .instr_end, .instr_ccr_op, .rte_req, .pc_in, .ccr_in, .sp_in, .cpu_hold,
    .pc_out, .pc_load, .condition_code_reg, .ccr_load, .stack_pointer_reg, .sp_load,
    .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata
);

// ---- tb/ias_mem_model.sv ----
`timescale 1ns/1ps
module ias_mem_model (
    input  wire logic        clock,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    input  wire logic        mem_we,
    input  wire logic        mem_re,
    output logic      [15:0] mem_rdata
);
    logic [15:0] mem [0:32767];
    logic [15:0] q_ff  = 16'h0000;
    logic        rd_ff = 1'b0;
    // every word holds 0x4000 plus its byte address, so vectors are predictable
    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 16'h4000 + 16'(2 * i);
        end
    end
    always @(posedge clock) begin
        rd_ff <= mem_re;
        if (mem_re) begin
            q_ff <= mem[mem_addr[15:1]];
        end
        if (mem_we) begin
            mem[mem_addr[15:1]] <= mem_wdata;
        end
    end
    // outside the data cycle the bus shows the inverse, never a stale copy
    assign mem_rdata = rd_ff ? q_ff : ~q_ff;
endmodule : ias_mem_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb
    import ias_pkg::*;
;
    logic        clock = 1'b0, rst = 1'b1, nmi_pin = 1'b1, rte_req = 1'b0;
    logic        instr_end = 1'b0, instr_ccr_op = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
    logic [7:0]  ext_lines_n = 8'hFF;
    logic [18:0] periph_req = '0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [15:0] pc_in = 16'h1234, sp_in = 16'h0200;
    logic [7:0]  ccr_in = 8'h80, condition_code_reg;
    logic [15:0] pc_out, stack_pointer_reg, mem_addr, mem_wdata, mem_rdata;
    logic        cpu_hold, pc_load, ccr_load, sp_load, mem_we, mem_re;
    int          n_mismatch = 0, checks_done = 0;
    always #5 clock = ~clock;
    ias_accept_seq u_ias_accept_seq (
        .clock, .rst, .nmi_pin, .ext_request_lines(ext_lines_n), .periph_req, .reg_addr,
        .reg_wdata, .reg_we, .reg_re, .reg_rdata, .instr_end, .instr_ccr_op, .rte_req, .pc_in,
        .ccr_in, .sp_in, .cpu_hold, .pc_out, .pc_load, .condition_code_reg, .ccr_load,
        .stack_pointer_reg, .sp_load, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata
    );
    ias_mem_model u_ias_mem_model (
        .clock, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_we    <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_re   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_re   <= 1'b0;
        #1;
        cmp("reg_rdata", exp, reg_rdata);
    endtask : reg_rd
    task automatic wait_pc;
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge clock);
            #1;
            if (pc_load === 1'b1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            $display("[ERR] pc_load expected 1 seen timeout");
            summarize();
        end
    endtask : wait_pc
    // a few idle cycles first so synchronised pins have settled
    task automatic pulse(input logic op);
        repeat (4) @(posedge clock);
        instr_end    <= 1'b1;
        instr_ccr_op <= op;
        @(posedge clock);
        instr_end    <= 1'b0;
        instr_ccr_op <= 1'b0;
    endtask : pulse
    task automatic no_accept(input logic op);
        pulse(op);
        repeat (3) begin
            @(posedge clock);
            #1;
            cmp("cpu_hold", 32'h0, 32'(cpu_hold));
        end
        // back on a rising edge so the caller drives inputs there
        @(posedge clock);
    endtask : no_accept
    task automatic enter(input logic [15:0] va);
        logic [15:0] top;
        pulse(1'b0);
        wait_pc();
        top = sp_in - 16'h0004;
        cmp("pc_out", 32'(16'h4000 + va), 32'(pc_out));
        cmp("sp_out", 32'(top), 32'(stack_pointer_reg));
        cmp("ccr_out", 32'(ccr_in | CCR_I_MASK), 32'(condition_code_reg));
        cmp("stack_pc", 32'(pc_in), 32'(u_ias_mem_model.mem[top[15:1] + 15'h0001]));
        cmp("stack_ccr", {16'h0, ccr_in, 8'h00}, 32'(u_ias_mem_model.mem[top[15:1]]));
        @(posedge clock);
    endtask : enter
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        wait_pc();
        cmp("reset_pc", 32'h0000_4000, 32'(pc_out));
        cmp("reset_ccr", 32'h0000_0080, 32'(condition_code_reg));
        reg_rd(OFS_CTRL, CTRL_RST);
        reg_rd(4'h2, 32'h0000_0000);
        pulse(1'b0);
        reg_wr(OFS_CTRL, 32'h0000_0809);
        ext_lines_n <= 8'hF6;
        repeat (3) @(posedge clock);
        ext_lines_n <= 8'hFE;
        repeat (4) @(posedge clock);
        reg_rd(OFS_PENDING, 32'h0000_0012);
        no_accept(1'b0);
        ccr_in <= 8'h00;
        no_accept(1'b1);
        enter(16'h0008);
        ext_lines_n <= 8'hFF;
        enter(16'h000E);
        periph_req <= 19'h4_0000;
        no_accept(1'b0);
        reg_wr(OFS_PER_EN, 32'h0004_0000);
        enter(16'h003C);
        periph_req <= '0;
        ccr_in     <= 8'hC5;
        nmi_pin    <= 1'b0;
        enter(16'h0006);
        sp_in <= 16'h01FC;
        @(posedge clock);
        rte_req <= 1'b1;
        @(posedge clock);
        rte_req <= 1'b0;
        wait_pc();
        cmp("ret_pc", 32'h0000_1234, 32'(pc_out));
        cmp("ret_ccr", 32'h0000_00C5, 32'(condition_code_reg));
        cmp("ret_sp", 32'h0000_0200, 32'(stack_pointer_reg));
        // pin is still low, so switching to the rising edge makes no edge by itself
        reg_wr(OFS_CTRL, 32'h0001_0809);
        sp_in   <= 16'h0200;
        nmi_pin <= 1'b1;
        enter(16'h0006);
        summarize();
    end
endmodule : tb
